// >>> rtl/flash_bus_host.sv
// Host controller that drives a parallel flash through its strobes and data pins.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_host
	import flash_host_pkg::*;
#(
	parameter int PROTECT_CYC = PROTECT_PULSE_CYC,
	parameter int RESET_CYC = RESET_PULSE_CYC
) (
	// Clock, reset and freeze.
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// User request side.
	input wire logic req_valid,
	input wire op_t req_op,
	input wire logic [20:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic req_word,
	output logic req_ready,
	// User answer side.
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	// Flash strobes and levels.
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_reset_n,
	output logic high_voltage_level,
	output logic width_word,
	output logic [19:0] flash_addr,
	// Flash data pins, split into input, output and enable.
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe
);
	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef struct packed {
		host_state_t st;
		op_t op;
		logic word;
		logic [15:0] wdata;
		logic ready;
		logic rsp_valid;
		logic [15:0] rdata;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
		logic hv;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic [15:0] dq_oe;
		logic [15:0] sync1;
		logic [15:0] sync2;
	} host_regs_t;

	localparam host_regs_t RESET_VAL = '{st: ST_IDLE, op: OP_READ, word: 1'b1,
		wdata: DATA_RESET, ready: 1'b1, rsp_valid: 1'b0, rdata: DATA_RESET,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, hv: 1'b0,
		addr: ADDR_RESET, dq_out: DATA_RESET, dq_oe: LANES_NONE,
		sync1: DATA_RESET, sync2: DATA_RESET};

	host_regs_t s_reg;
	host_regs_t s_next;
	timer_if #(.W(TIMER_W)) tmr ();

	initial begin
		if (PROTECT_CYC < 1 || PROTECT_CYC >= (1 << TIMER_W)) $error("PROTECT_CYC out of range");
		if (RESET_CYC < 1 || RESET_CYC >= (1 << TIMER_W)) $error("RESET_CYC out of range");
	end

	cycle_timer #(.W(TIMER_W)) u_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.tmr(tmr)
	);

	// Cycle count for a phase, cut to the timer width.
	function automatic logic [TIMER_W-1:0] cyc(input int n);
		return TIMER_W'(n);
	endfunction : cyc

	// Data lanes the host drives for a write: the low byte only in byte mode.
	function automatic logic [15:0] write_lanes(input logic word);
		return word ? LANES_WORD : LANES_BYTE;
	endfunction : write_lanes

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	// One bus operation at a time; every phase length comes from the timer.
	always_comb begin
		s_next = s_reg;
		tmr.load = 1'b0;
		tmr.count = cyc(1);
		s_next.rsp_valid = 1'b0;
		// Data pins cross into this clock through two flops.
		s_next.sync1 = dq_in;
		s_next.sync2 = s_reg.sync1;
		unique case (s_reg.st)
			ST_IDLE: begin
				if (req_valid) begin
					s_next.ready = 1'b0;
					s_next.op = req_op;
					s_next.word = req_word;
					s_next.wdata = req_wdata;
					// Word mode takes address 19..0, byte mode shifts in the extra low bit.
					s_next.addr = req_word ? req_addr[19:0] : req_addr[20:1];
					s_next.dq_out = req_word ? DATA_RESET : {req_addr[0], 15'h0000};
					// In byte mode pin 15 carries the least address bit for a whole read or write; protect and reset float it.
					s_next.dq_oe = req_word ? LANES_NONE : LANE_ADDR_LSB;
					tmr.load = 1'b1;
					unique case (req_op)
						OP_RESET: begin
							// Reset pulse floats and idles every other pin.
							s_next.rst_n = 1'b0;
							s_next.dq_oe = LANES_NONE;
							tmr.count = cyc(RESET_CYC);
							s_next.st = ST_RESET;
						end
						OP_PROTECT, OP_UNPROTECT: begin
							// Select bits force protect or unprotect on the sector address.
							s_next.addr[PROT_HI_BIT] = 1'b1;
							s_next.addr[PROT_LO_BIT] = 1'b0;
							s_next.addr[PROT_SEL_BIT] = (req_op == OP_UNPROTECT);
							s_next.hv = 1'b1;
							s_next.dq_oe = LANES_NONE;
							tmr.count = cyc(HV_SETUP_CYC);
							s_next.st = ST_HV_SETUP;
						end
						default: begin
							s_next.ce_n = 1'b0;
							tmr.count = cyc(ADDR_SETUP_CYC);
							s_next.st = ST_SETUP;
						end
					endcase
				end
			end
			ST_HV_SETUP: begin
				if (tmr.expired) begin
					s_next.ce_n = 1'b0;
					tmr.load = 1'b1;
					tmr.count = cyc(ADDR_SETUP_CYC);
					s_next.st = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (tmr.expired) begin
					tmr.load = 1'b1;
					if (s_reg.op == OP_READ || s_reg.op == OP_ID_READ) begin
						// Read: output gate low, write strobe stays high.
						s_next.oe_n = 1'b0;
						tmr.count = cyc(READ_ACCESS_CYC + SYNC_STAGES + 1);
						s_next.st = ST_READ;
					end else begin
						// Write or sector protect: write strobe low, output gate high.
						s_next.we_n = 1'b0;
						if (s_reg.op == OP_WRITE) begin
							s_next.dq_out[7:0] = s_reg.wdata[7:0];
							if (s_reg.word) begin
								s_next.dq_out = s_reg.wdata;
							end
							s_next.dq_oe = s_reg.dq_oe | write_lanes(s_reg.word);
						end
						tmr.count = s_reg.hv ? cyc(PROTECT_CYC) : cyc(WRITE_PULSE_CYC);
						s_next.st = ST_WRITE;
					end
				end
			end
			ST_READ: begin
				if (tmr.expired) begin
					// Identification codes and byte reads use the low eight lanes only.
					if (s_reg.word && s_reg.op == OP_READ) begin
						s_next.rdata = s_reg.sync2;
					end else begin
						s_next.rdata = {8'h00, s_reg.sync2[7:0]};
					end
					s_next.oe_n = 1'b1;
					s_next.ce_n = 1'b1;
					s_next.dq_oe = LANES_NONE;
					s_next.rsp_valid = 1'b1;
					tmr.load = 1'b1;
					tmr.count = cyc(RECOVER_CYC);
					s_next.st = ST_RECOVER;
				end
			end
			ST_WRITE: begin
				if (tmr.expired) begin
					// Each write is one bus cycle, so a two-write program is two requests.
					s_next.we_n = 1'b1;
					tmr.load = 1'b1;
					tmr.count = cyc(DATA_HOLD_CYC);
					s_next.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (tmr.expired) begin
					s_next.ce_n = 1'b1;
					s_next.hv = 1'b0;
					s_next.dq_oe = LANES_NONE;
					s_next.rsp_valid = 1'b1;
					tmr.load = 1'b1;
					tmr.count = cyc(RECOVER_CYC);
					s_next.st = ST_RECOVER;
				end
			end
			ST_RESET: begin
				if (tmr.expired) begin
					s_next.rst_n = 1'b1;
					s_next.rsp_valid = 1'b1;
					tmr.load = 1'b1;
					tmr.count = cyc(RECOVER_CYC);
					s_next.st = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (tmr.expired) begin
					s_next.ready = 1'b1;
					s_next.st = ST_IDLE;
				end
			end
		endcase
		// Timer loads only count while the clock enable lets state move.
		if (!clk_en) begin
			tmr.load = 1'b0;
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_reg <= RESET_VAL;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	// Every output is a field of the state register.
	assign req_ready = s_reg.ready;
	assign rsp_valid = s_reg.rsp_valid;
	assign rsp_rdata = s_reg.rdata;
	assign flash_ce_n = s_reg.ce_n;
	assign flash_oe_n = s_reg.oe_n;
	assign flash_we_n = s_reg.we_n;
	assign flash_reset_n = s_reg.rst_n;
	assign high_voltage_level = s_reg.hv;
	assign width_word = s_reg.word;
	assign flash_addr = s_reg.addr;
	assign dq_out = s_reg.dq_out;
	assign dq_oe = s_reg.dq_oe;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_read_strobes: assert property (
		!s_reg.oe_n |-> !s_reg.ce_n && s_reg.we_n && s_reg.rst_n)
		else $error("Output gate low outside a proper read.");
	chk_write_strobes: assert property (
		!s_reg.we_n |-> !s_reg.ce_n && s_reg.oe_n)
		else $error("Write strobe low outside a proper write.");
	chk_no_contention: assert property (
		!s_reg.oe_n |-> s_reg.dq_oe[14:0] == 15'h0000)
		else $error("Host drives data while the device may.");
	chk_byte_lanes: assert property (
		!s_reg.word |-> s_reg.dq_oe[14:8] == 7'h00)
		else $error("Upper lanes driven in byte mode.");
	chk_protect_addr: assert property (
		s_reg.hv && !s_reg.we_n && s_reg.op == OP_PROTECT |->
		!s_reg.addr[6] && s_reg.addr[1:0] == 2'b10)
		else $error("Protect write with wrong select bits.");
	chk_unprotect_addr: assert property (
		s_reg.hv && !s_reg.we_n && s_reg.op == OP_UNPROTECT |->
		s_reg.addr[6] && s_reg.addr[1:0] == 2'b10)
		else $error("Unprotect write with wrong select bits.");
	chk_reset_quiet: assert property (
		!s_reg.rst_n |-> s_reg.ce_n && s_reg.oe_n && s_reg.we_n && s_reg.dq_oe == 16'h0000)
		else $error("Activity on the bus during reset pulse.");
	chk_write_pulse: assert property (
		clk_en && $fell(s_reg.we_n) && !s_reg.hv |-> !s_reg.we_n [*2])
		else $error("Write pulse shorter than its minimum.");
	chk_reset_start: assert property (
		clk_en && s_reg.st == ST_IDLE && req_valid && req_op == OP_RESET |=>
		!s_reg.rst_n && !s_reg.ready)
		else $error("Reset request did not start a reset pulse.");

endmodule : flash_bus_host
`default_nettype wire

// >>> rtl/flash_host_pkg.sv
// Constants, types and the operation summary of the flash bus host controller.
//
// Operation
// - Host reads with select and output gate low, write strobe high, address valid.
// - Host writes with write strobe and select low, output gate held high.
// - Shortened program mode programs a location with two writes, not four.
// - High-voltage reset, write with bit6 low, bit1 high, bit0 low protects.
// - Same conditions with bit6 high unprotect the addressed sector.
package flash_host_pkg;

	// ----------------------------------------------------------------------
	// Clock and cycle timing
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000;

	// Least time in nanoseconds to a whole number of cycles, rounded up.
	function automatic int min_cycles(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : min_cycles

	localparam int ADDR_SETUP_NS = 25;
	localparam int READ_ACCESS_NS = 120;
	localparam int WRITE_PULSE_NS = 50;
	localparam int DATA_HOLD_NS = 25;
	localparam int RESET_PULSE_NS = 500;
	localparam int RECOVER_NS = 50;
	localparam int HV_SETUP_NS = 4000;
	localparam int PROTECT_PULSE_NS = 150000;
	localparam int ADDR_SETUP_CYC = min_cycles(ADDR_SETUP_NS);
	localparam int READ_ACCESS_CYC = min_cycles(READ_ACCESS_NS);
	localparam int WRITE_PULSE_CYC = min_cycles(WRITE_PULSE_NS);
	localparam int DATA_HOLD_CYC = min_cycles(DATA_HOLD_NS);
	localparam int RESET_PULSE_CYC = min_cycles(RESET_PULSE_NS);
	localparam int RECOVER_CYC = min_cycles(RECOVER_NS);
	localparam int HV_SETUP_CYC = min_cycles(HV_SETUP_NS);
	localparam int PROTECT_PULSE_CYC = min_cycles(PROTECT_PULSE_NS);
	// Two synchroniser stages sit between the data pins and the capture.
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------------
	// Widths, field positions and values after reset
	// ----------------------------------------------------------------------
	localparam int TIMER_W = 13;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int PROT_SEL_BIT = 6;
	localparam int PROT_HI_BIT = 1;
	localparam int PROT_LO_BIT = 0;
	localparam int LANE15_BIT = 15;
	localparam logic [15:0] LANES_NONE = 16'h0000;
	localparam logic [15:0] LANES_WORD = 16'hFFFF;
	localparam logic [15:0] LANES_BYTE = 16'h00FF;
	localparam logic [15:0] LANE_ADDR_LSB = 16'h8000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [19:0] ADDR_RESET = 20'h00000;

	// ----------------------------------------------------------------------
	// Operations and states
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ,
		OP_ID_READ,
		OP_WRITE,
		OP_PROTECT,
		OP_UNPROTECT,
		OP_RESET
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HV_SETUP,
		ST_SETUP,
		ST_READ,
		ST_WRITE,
		ST_HOLD,
		ST_RESET,
		ST_RECOVER
	} host_state_t;

endpackage : flash_host_pkg

// >>> rtl/timer_if.sv
// Load and expiry signals between the controller and its cycle timer.
`timescale 1ns/10ps
`default_nettype none
interface timer_if #(parameter int W = 13);
	logic load;
	logic [W-1:0] count;
	logic expired;
	modport ctrl (output load, output count, input expired);
	modport timer (input load, input count, output expired);
endinterface : timer_if
`default_nettype wire

// >>> rtl/cycle_timer.sv
// Down counter that marks the last cycle of a timed bus phase.
`timescale 1ns/10ps
`default_nettype none
module cycle_timer
	import flash_host_pkg::*;
#(
	parameter int W = TIMER_W
) (
	// Clock, reset and freeze.
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Controller side.
	timer_if.timer tmr
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} timer_state_t;

	timer_state_t s_reg;
	timer_state_t s_next;

	initial begin
		if (W < 2) $error("cycle_timer width too small");
	end

	// A load of N makes the phase last N cycles; expiry marks its last one.
	always_comb begin
		s_next = s_reg;
		if (tmr.load) begin
			s_next.cnt = tmr.count - W'(1);
		end else if (s_reg.cnt != '0) begin
			s_next.cnt = s_reg.cnt - W'(1);
		end
	end

	assign tmr.expired = (s_reg.cnt == '0);

	// State register, frozen while the clock enable is low.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	chk_timer_reload: assert property (@(posedge core_clk) disable iff (!reset_n)
		clk_en && tmr.load && tmr.count == W'(1) |=> tmr.expired)
		else $error("Timer did not expire after a one-cycle load.");

endmodule : cycle_timer
`default_nettype wire

// >>> dv/flash_dev_model.sv
// Behavioural parallel flash that answers the host controller's bus cycles.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
	parameter logic [7:0] ID_CODE = 8'h5A, // Arbitrary identification value.
	parameter logic [7:0] CMD_PROG = 8'hA0,
	parameter logic [7:0] CMD_ID = 8'h90,
	parameter logic [7:0] CMD_EXIT = 8'hF0,
	parameter logic [7:0] CMD_ERASE = 8'h80,
	parameter logic [7:0] CMD_SECTOR = 8'h30,
	parameter logic [7:0] CMD_CHIP = 8'h10
) (
	// Strobes and levels.
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic rst_n,
	input wire logic hv,
	input wire logic word,
	input wire logic [19:0] addr,
	// Data pins.
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic [15:0] dq_en,
	output logic prot
);
	logic [15:0] mem [16];
	logic [15:0] rd;
	logic id_mode = 1'b0;
	logic prog_next = 1'b0;
	logic erase_next = 1'b0;
	logic [3:0] wa;
	assign wa = addr[3:0];

	// Array starts with a known pattern; protection starts clear.
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'h3C00 + 16'(i) * 16'h0111;
		prot = 1'b0;
	end

	// Data drive only for a defined read cycle; pin fifteen is an address in byte mode.
	always_comb begin
		dq_o = 16'h0000;
		dq_en = 16'h0000;
		rd = id_mode ? {ID_CODE, ID_CODE} : mem[wa];
		if (!ce_n && !oe_n && we_n && rst_n) begin
			if (word) begin
				dq_o = rd;
				dq_en = 16'hFFFF;
			end else begin
				dq_o[7:0] = dq_i[15] ? rd[15:8] : rd[7:0];
				dq_en = 16'h00FF;
			end
		end
	end

	// Command latches capture address and data on the closing write strobe edge.
	always @(posedge we_n or negedge rst_n) begin
		if (!rst_n) begin
			id_mode <= 1'b0;
			prog_next <= 1'b0;
			erase_next <= 1'b0;
		end else if (!ce_n && oe_n) begin
			if (hv && addr[1] && !addr[0]) begin
				prot <= !addr[6];
			end else if (prog_next) begin
				prog_next <= 1'b0;
				if (word) mem[wa] <= dq_i;
				else if (dq_i[15]) mem[wa][15:8] <= dq_i[7:0];
				else mem[wa][7:0] <= dq_i[7:0];
			end else if (erase_next) begin
				// Sector erases may follow one another; a new erase setup re-arms.
				erase_next <= (dq_i[7:0] == CMD_SECTOR) || (dq_i[7:0] == CMD_ERASE);
				if (dq_i[7:0] == CMD_SECTOR) begin
					// A sector is named by the top two word address bits of this array.
					for (int i = 0; i < 4; i++) mem[{wa[3:2], 2'(i)}] <= 16'hFFFF;
				end
				if (dq_i[7:0] == CMD_CHIP) begin
					for (int i = 0; i < 16; i++) mem[i] <= 16'hFFFF;
				end
			end else begin
				prog_next <= (dq_i[7:0] == CMD_PROG);
				erase_next <= (dq_i[7:0] == CMD_ERASE);
				if (dq_i[7:0] == CMD_ID) id_mode <= 1'b1;
				if (dq_i[7:0] == CMD_EXIT) id_mode <= 1'b0;
			end
		end
	end
endmodule : flash_dev_model
`default_nettype wire

// >>> dv/flash_bus_operation_decode_tb.sv
// Self-checking bench of the flash bus host against a behavioural flash.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_operation_decode_tb;
	import flash_host_pkg::*;
	localparam logic [7:0] ID_VAL = 8'h5A; // Arbitrary identification value.
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic req_valid = 1'b0;
	op_t req_op = OP_READ;
	logic [20:0] req_addr = 21'h000000;
	logic [15:0] req_wdata = 16'h0000;
	logic req_word = 1'b1;
	logic req_ready, rsp_valid, ce_n, oe_n, we_n, frst_n, hv, width_word, prot;
	logic [15:0] rsp_rdata, dq_in, dq_out, dq_oe, dev_o, dev_en, r;
	logic [15:0] float_pat = 16'hA5C3;
	logic [19:0] flash_addr;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;

	// Clock of 25 ns.
	always #12.5 core_clk = ~core_clk;

	flash_bus_host #(.PROTECT_CYC(4), .RESET_CYC(3)) flash_bus_host_i (.core_clk(core_clk),
		.reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid), .req_op(req_op),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_word(req_word), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
		.flash_we_n(we_n), .flash_reset_n(frst_n), .high_voltage_level(hv),
		.width_word(width_word), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe));

	flash_dev_model #(.ID_CODE(ID_VAL)) flash_dev_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.rst_n(frst_n), .hv(hv), .word(width_word), .addr(flash_addr), .dq_i(dq_in),
		.dq_o(dev_o), .dq_en(dev_en), .prot(prot));

	// Wire level: host, then flash, else a pattern that changes every cycle.
	assign dq_in = (dq_oe & dq_out) | (~dq_oe & dev_en & dev_o) | (~dq_oe & ~dev_en & float_pat);
	always @(posedge core_clk) float_pat <= ~float_pat;

	// Initial array word, worked out independently of the model.
	function automatic logic [15:0] init_word(input int i);
		return 16'h3C00 + 16'(i) * 16'h0111;
	endfunction : init_word

	task automatic check(input string name, input logic [20:0] got, input logic [20:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// Watchdog on the whole run.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			finish_test();
		end
	end

	// Pin levels watched on every cycle.
	always @(posedge core_clk) begin
		if (reset_n) begin
			check("strobe_mix", {20'h00000, ~oe_n & ~we_n}, 21'h000000);
			check("contention", 21'(dq_oe & dev_en), 21'h000000);
			if (!we_n) check("write_gate", {20'h00000, oe_n}, 21'h000001);
			if (!ce_n && !width_word) check("byte_lanes", 21'(dq_oe & 16'hFF00), 21'h008000);
		end
	end

	// One user request, held until taken, then the answer is collected.
	task automatic op(input op_t o, input logic [20:0] a, input logic [15:0] d, input logic w);
		int n;
		req_op <= o;
		req_addr <= a;
		req_wdata <= d;
		req_word <= w;
		req_valid <= 1'b1;
		n = 0;
		do begin @(posedge core_clk); n++; end while (req_ready !== 1'b1 && n < 300);
		req_valid <= 1'b0;
		n = 0;
		do begin @(posedge core_clk); #1; n++; end while (rsp_valid !== 1'b1 && n < 300);
		if (n >= 300) begin
			fail_count++;
			finish_test();
		end
		r = rsp_rdata;
		@(posedge core_clk);
	endtask : op

	// Pins after reset: strobes high, word width, nothing driven.
	task automatic t_idle;
		@(posedge core_clk);
		#1;
		check("idle_pins", 21'({ce_n, oe_n, we_n, frst_n, hv, width_word}), 21'h00003D);
		check("idle_dq", 21'(dq_oe), 21'h000000);
		@(posedge core_clk);
	endtask : t_idle

	// Reads with no command, in word and in byte width.
	task automatic t_read;
		op(OP_READ, 21'h000003, 16'h0000, 1'b1);
		check("rd_word", 21'(r), 21'(init_word(3)));
		op(OP_READ, 21'h000006, 16'h0000, 1'b0);
		check("rd_lo", 21'(r), 21'(init_word(3) & 16'h00FF));
		op(OP_READ, 21'h000007, 16'h0000, 1'b0);
		check("rd_hi", 21'(r), 21'(init_word(3) >> 8));
	endtask : t_read

	// Short and standard program sequences, word and byte.
	task automatic t_program;
		op(OP_WRITE, 21'h000002, 16'h00A0, 1'b1);
		op(OP_WRITE, 21'h000005, 16'h1234, 1'b1);
		op(OP_READ, 21'h000005, 16'h0000, 1'b1);
		check("prog_short", 21'(r), 21'h001234);
		op(OP_READ, 21'h000002, 16'h0000, 1'b1);
		check("cmd_no_map", 21'(r), 21'(init_word(2)));
		op(OP_WRITE, 21'h000AAA, 16'h00AA, 1'b0);
		op(OP_WRITE, 21'h000555, 16'h0055, 1'b0);
		op(OP_WRITE, 21'h000AAA, 16'h00A0, 1'b0);
		op(OP_WRITE, 21'h00000D, 16'h0077, 1'b0);
		op(OP_READ, 21'h000006, 16'h0000, 1'b1);
		check("prog_byte", 21'(r), 21'({8'h77, 8'(init_word(6))}));
	endtask : t_program

	// A read frozen by the clock enable holds its strobes, then completes.
	task automatic t_freeze;
		fork
			op(OP_READ, 21'h000005, 16'h0000, 1'b1);
			begin
				repeat (4) @(posedge core_clk);
				clk_en <= 1'b0;
				repeat (10) @(posedge core_clk);
				#1;
				check("frz_hold", 21'({ce_n, oe_n, rsp_valid}), 21'h000000);
				@(posedge core_clk);
				clk_en <= 1'b1;
			end
		join
		check("frz_read", 21'(r), 21'h001234);
	endtask : t_freeze

	// Erase of two sectors, then of the whole array.
	task automatic t_erase;
		op(OP_WRITE, 21'h000000, 16'h0080, 1'b1);
		op(OP_WRITE, 21'h000001, 16'h0030, 1'b1);
		op(OP_WRITE, 21'h000009, 16'h0030, 1'b1);
		op(OP_READ, 21'h000002, 16'h0000, 1'b1);
		check("ers_sec0", 21'(r), 21'h00FFFF);
		op(OP_READ, 21'h00000B, 16'h0000, 1'b1);
		check("ers_sec2", 21'(r), 21'h00FFFF);
		op(OP_READ, 21'h000005, 16'h0000, 1'b1);
		check("ers_keep", 21'(r), 21'h001234);
		op(OP_WRITE, 21'h000000, 16'h0080, 1'b1);
		op(OP_WRITE, 21'h000000, 16'h0010, 1'b1);
		op(OP_READ, 21'h000005, 16'h0000, 1'b1);
		check("ers_chip", 21'(r), 21'h00FFFF);
	endtask : t_erase

	// Identification mode, then a hardware reset back to array reads.
	task automatic t_id_reset;
		op(OP_WRITE, 21'h000555, 16'h0090, 1'b1);
		op(OP_ID_READ, 21'h000000, 16'h0000, 1'b1);
		check("id_code", 21'(r), 21'(ID_VAL));
		op(OP_RESET, 21'h000000, 16'h0000, 1'b1);
		op(OP_READ, 21'h000001, 16'h0000, 1'b1);
		check("after_rst", 21'(r), 21'(init_word(1)));
	endtask : t_id_reset

	// High-voltage protect and unprotect of one sector.
	task automatic t_protect;
		op(OP_PROTECT, 21'h0F8000, 16'h0000, 1'b1);
		check("protect", {20'h00000, prot}, 21'h000001);
		op(OP_UNPROTECT, 21'h0F8000, 16'h0000, 1'b1);
		check("unprotect", {20'h00000, prot}, 21'h000000);
	endtask : t_protect

	// Main sequence.
	initial begin
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		t_idle();
		t_read();
		t_program();
		t_freeze();
		t_id_reset();
		t_erase();
		t_protect();
		finish_test();
	end
endmodule : flash_bus_operation_decode_tb
`default_nettype wire
